// ===== bit_ops_pkg.sv
// Constants, opcodes and status-bit positions for the bit-op and transfer execution unit.
// Assumes an outer core decodes instructions into the operation codes given here.
package bit_ops_pkg;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_PMEM_LOAD = 5'h01,
        OP_EXT_PMEM_LOAD = 5'h02,
        OP_PUSH = 5'h03,
        OP_POP = 5'h04,
        OP_IO_BIT_SET = 5'h05,
        OP_IO_BIT_CLEAR = 5'h06,
        OP_SHL = 5'h07,
        OP_SHR = 5'h08,
        OP_RCL = 5'h09,
        OP_RCR = 5'h0A,
        OP_SAR = 5'h0B,
        OP_BIT_STORE = 5'h0C,
        OP_BIT_LOAD = 5'h0D,
        OP_FLAG_SET = 5'h0E,
        OP_FLAG_CLEAR = 5'h0F,
        OP_SLEEP = 5'h10,
        OP_WATCHDOG = 5'h11,
        OP_BREAK = 5'h12
    } op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_STEP1 = 2'h1,
        ST_STEP2 = 2'h3
    } state_type;

    // Status register bit positions.
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] PAGE_EXT_RESET = 8'h00;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Cycle counts of the multi-cycle operations.
    localparam int PMEM_LOAD_CYCLES = 3;
    localparam int STACK_CYCLES = 2;
    localparam int IO_BIT_CYCLES = 2;
endpackage

// ===== bit_ops_properties.sv
// Concurrent checks on the execution unit's ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module bit_ops_properties (
    // Clock, reset and issue side
    input wire logic clk,
    input wire logic reset_n,
    input wire logic issue,
    input wire bit_ops_pkg::op_type op,
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_index,
    input wire logic [7:0] program_memory_data,
    input wire logic [7:0] stack_data,
    input wire logic [7:0] io_data,
    // Outputs of the unit
    input wire logic busy,
    input wire logic done,
    input wire logic [7:0] status_register,
    input wire logic [15:0] pointer,
    input wire logic [7:0] page_extension_register,
    input wire logic [7:0] result,
    input wire logic [23:0] program_memory_address,
    input wire logic program_memory_read,
    input wire logic stack_write,
    input wire logic [7:0] stack_write_data,
    input wire logic io_write,
    input wire logic [7:0] io_write_data,
    input wire logic sleep_request,
    input wire logic debug_break
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // An issue counts only when the unit is idle; requests while busy are dropped silently.
    logic taken;
    assign taken = issue && !busy;
    a_load_three_cycles:
        assert property (taken && op inside {bit_ops_pkg::OP_PMEM_LOAD, bit_ops_pkg::OP_EXT_PMEM_LOAD}
            |=> program_memory_read ##1 !done ##1 (done && result == $past(program_memory_data)))
        else $error("load did not complete with memory data on its third cycle");
    a_load_flags_kept:
        assert property (taken && op inside {bit_ops_pkg::OP_PMEM_LOAD, bit_ops_pkg::OP_EXT_PMEM_LOAD}
            |=> $stable(status_register) [*3])
        else $error("status changed during a load");
    a_ext_address:
        assert property (taken && op == bit_ops_pkg::OP_EXT_PMEM_LOAD
            |=> program_memory_address == {$past(page_extension_register), $past(pointer)})
        else $error("extended load address is not page above pointer");
    a_push_two_cycles:
        assert property (taken && op == bit_ops_pkg::OP_PUSH
            |=> stack_write && stack_write_data == $past(operand) ##1 done && !stack_write)
        else $error("push did not write the operand and finish in two cycles");
    a_pop_two_cycles:
        assert property (taken && op == bit_ops_pkg::OP_POP |=> !done ##1 (done && result == $past(stack_data)))
        else $error("pop did not return stack data on its second cycle");
    a_io_bit_set:
        assert property (taken && op == bit_ops_pkg::OP_IO_BIT_SET
            |=> ##1 io_write && io_write_data == ($past(io_data) | (8'h01 << $past(bit_index, 2))))
        else $error("io bit set wrote a wrong value");
    a_shift_flags:
        assert property (taken && op inside {[bit_ops_pkg::OP_SHL:bit_ops_pkg::OP_SAR]}
            |=> done && status_register[3] == (status_register[2] ^ status_register[0])
            && status_register[2] == result[7] && status_register[1] == (result == 8'h00))
        else $error("shift flags do not match the result");
    a_flag_set_index:
        assert property (taken && op == bit_ops_pkg::OP_FLAG_SET
            |=> status_register == ($past(status_register) | (8'h01 << $past(bit_index))))
        else $error("flag set touched the wrong status bit");
    a_sleep_issue:
        assert property (taken && op == bit_ops_pkg::OP_SLEEP |=> sleep_request && done && $stable(status_register))
        else $error("sleep did not pulse in one cycle with flags kept");
    a_break_only_debug:
        assert property (taken && op == bit_ops_pkg::OP_BREAK |=> debug_break && !done)
        else $error("break did not reach only the debug facility");
    c_ext_load: cover property (taken && op == bit_ops_pkg::OP_EXT_PMEM_LOAD);
    c_refused: cover property (issue && busy);
    c_io_clear: cover property (taken && op == bit_ops_pkg::OP_IO_BIT_CLEAR);
endmodule

bind bit_ops_transfer_exec bit_ops_properties props (.clk, .reset_n, .issue, .op, .operand, .bit_index,
    .program_memory_data, .stack_data, .io_data, .busy, .done, .status_register, .pointer,
    .page_extension_register, .result, .program_memory_address, .program_memory_read, .stack_write,
    .stack_write_data, .io_write, .io_write_data, .sleep_request, .debug_break);

// ===== bit_ops_transfer_exec.sv
// Execution unit for program-memory loads, stack moves, I/O bit ops, shifts, flag ops and control ops.
// Assumes one operation is started per issue pulse and the next waits until busy falls.
`timescale 1ns/1ns
module bit_ops_transfer_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Operation issue
    input wire logic issue,
    input wire bit_ops_pkg::op_type op,
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_index,
    input wire logic post_increment,
    // Pointer and page extension load from the core
    input wire logic pointer_load,
    input wire logic [15:0] pointer_value,
    input wire logic page_extension_load,
    input wire logic [7:0] page_extension_value,
    // Memory read data
    input wire logic [7:0] program_memory_data,
    input wire logic [7:0] stack_data,
    input wire logic [7:0] io_data,
    // Status and results
    output logic busy,
    output logic done,
    output logic [7:0] status_register,
    output logic [15:0] pointer,
    output logic [7:0] page_extension_register,
    output logic [7:0] result,
    output logic result_write,
    // Memory strobes
    output logic [23:0] program_memory_address,
    output logic program_memory_read,
    output logic stack_write,
    output logic stack_read,
    output logic [7:0] stack_write_data,
    output logic io_read,
    output logic io_write,
    output logic [7:0] io_write_data,
    // Control pulses
    output logic sleep_request,
    output logic watchdog_restart,
    output logic debug_break
);
    bit_ops_pkg::state_type state_q, state_d;
    bit_ops_pkg::op_type op_q, op_d;
    logic [2:0] index_q, index_d;
    logic inc_q, inc_d;
    logic [7:0] flag_q, flag_d;
    logic [15:0] ptr_q, ptr_d;
    logic [7:0] page_q, page_d;
    logic [7:0] result_q, result_d;
    logic result_write_q, result_write_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [23:0] pm_addr_q, pm_addr_d;
    logic pm_read_q, pm_read_d;
    logic stack_write_q, stack_write_d;
    logic stack_read_q, stack_read_d;
    logic [7:0] stack_wdata_q, stack_wdata_d;
    logic io_read_q, io_read_d;
    logic io_write_q, io_write_d;
    logic [7:0] io_wdata_q, io_wdata_d;
    logic sleep_q, sleep_d;
    logic wdt_q, wdt_d;
    logic break_q, break_d;
    logic [23:0] full_address;
    logic [23:0] full_next;

    exec_if shift_bus ();

    shift_unit shifter (
        .bus(shift_bus)
    );

    assign shift_bus.op = op;
    assign shift_bus.operand = operand;
    assign shift_bus.carry_in = flag_q[bit_ops_pkg::FLAG_C];
    assign full_address = {page_q, ptr_q};
    assign full_next = full_address + 24'h000001;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        index_d = index_q;
        inc_d = inc_q;
        flag_d = flag_q;
        ptr_d = ptr_q;
        page_d = page_q;
        result_d = result_q;
        result_write_d = 1'b0;
        busy_d = busy_q;
        done_d = 1'b0;
        pm_addr_d = pm_addr_q;
        pm_read_d = 1'b0;
        stack_write_d = 1'b0;
        stack_read_d = 1'b0;
        stack_wdata_d = stack_wdata_q;
        io_read_d = 1'b0;
        io_write_d = 1'b0;
        io_wdata_d = io_wdata_q;
        sleep_d = 1'b0;
        wdt_d = 1'b0;
        break_d = 1'b0;
        if (pointer_load) begin
            ptr_d = pointer_value;
        end
        if (page_extension_load) begin
            page_d = page_extension_value;
        end
        unique case (state_q)
            bit_ops_pkg::ST_IDLE: begin
                if (issue) begin
                    op_d = op;
                    index_d = bit_index;
                    inc_d = post_increment;
                    unique case (op)
                        bit_ops_pkg::OP_PMEM_LOAD: begin
                            pm_addr_d = {8'h00, ptr_q};
                            pm_read_d = 1'b1;
                            busy_d = 1'b1;
                            state_d = bit_ops_pkg::ST_STEP1;
                        end
                        bit_ops_pkg::OP_EXT_PMEM_LOAD: begin
                            pm_addr_d = full_address;
                            pm_read_d = 1'b1;
                            busy_d = 1'b1;
                            state_d = bit_ops_pkg::ST_STEP1;
                        end
                        bit_ops_pkg::OP_PUSH: begin
                            stack_wdata_d = operand;
                            stack_write_d = 1'b1;
                            busy_d = 1'b1;
                            state_d = bit_ops_pkg::ST_STEP2;
                        end
                        bit_ops_pkg::OP_POP: begin
                            stack_read_d = 1'b1;
                            busy_d = 1'b1;
                            state_d = bit_ops_pkg::ST_STEP2;
                        end
                        bit_ops_pkg::OP_IO_BIT_SET, bit_ops_pkg::OP_IO_BIT_CLEAR: begin
                            io_read_d = 1'b1;
                            busy_d = 1'b1;
                            state_d = bit_ops_pkg::ST_STEP2;
                        end
                        bit_ops_pkg::OP_SHL, bit_ops_pkg::OP_SHR, bit_ops_pkg::OP_RCL,
                        bit_ops_pkg::OP_RCR, bit_ops_pkg::OP_SAR: begin
                            result_d = shift_bus.result;
                            result_write_d = 1'b1;
                            flag_d[bit_ops_pkg::FLAG_C] = shift_bus.carry_out;
                            flag_d[bit_ops_pkg::FLAG_Z] = shift_bus.zero;
                            flag_d[bit_ops_pkg::FLAG_N] = shift_bus.negative;
                            flag_d[bit_ops_pkg::FLAG_V] = shift_bus.overflow;
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_BIT_STORE: begin
                            flag_d[bit_ops_pkg::FLAG_T] = operand[bit_index];
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_BIT_LOAD: begin
                            result_d = operand;
                            result_d[bit_index] = flag_q[bit_ops_pkg::FLAG_T];
                            result_write_d = 1'b1;
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_FLAG_SET: begin
                            // Named set ops (carry, zero, I and the rest) decode to an index here.
                            flag_d[bit_index] = 1'b1;
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_FLAG_CLEAR: begin
                            flag_d[bit_index] = 1'b0;
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_SLEEP: begin
                            sleep_d = 1'b1;
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_WATCHDOG: begin
                            wdt_d = 1'b1;
                            done_d = 1'b1;
                        end
                        bit_ops_pkg::OP_BREAK: begin
                            // Only the debug facility acts on this; no completion is reported.
                            break_d = 1'b1;
                        end
                        default: begin
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            bit_ops_pkg::ST_STEP1: begin
                state_d = bit_ops_pkg::ST_STEP2;
            end
            bit_ops_pkg::ST_STEP2: begin
                state_d = bit_ops_pkg::ST_IDLE;
                busy_d = 1'b0;
                done_d = 1'b1;
                unique case (op_q)
                    bit_ops_pkg::OP_PMEM_LOAD: begin
                        result_d = program_memory_data;
                        result_write_d = 1'b1;
                        if (inc_q) begin
                            ptr_d = ptr_q + 16'h0001;
                        end
                    end
                    bit_ops_pkg::OP_EXT_PMEM_LOAD: begin
                        result_d = program_memory_data;
                        result_write_d = 1'b1;
                        if (inc_q) begin
                            page_d = full_next[23:16];
                            ptr_d = full_next[15:0];
                        end
                    end
                    bit_ops_pkg::OP_POP: begin
                        result_d = stack_data;
                        result_write_d = 1'b1;
                    end
                    bit_ops_pkg::OP_IO_BIT_SET: begin
                        io_wdata_d = io_data;
                        io_wdata_d[index_q] = 1'b1;
                        io_write_d = 1'b1;
                    end
                    bit_ops_pkg::OP_IO_BIT_CLEAR: begin
                        io_wdata_d = io_data;
                        io_wdata_d[index_q] = 1'b0;
                        io_write_d = 1'b1;
                    end
                    default: begin
                        result_d = result_q;
                    end
                endcase
            end
            default: begin
                state_d = bit_ops_pkg::ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= bit_ops_pkg::ST_IDLE;
            op_q <= bit_ops_pkg::OP_NOP;
            index_q <= 3'h0;
            inc_q <= 1'b0;
            flag_q <= bit_ops_pkg::STATUS_RESET;
            ptr_q <= bit_ops_pkg::POINTER_RESET;
            page_q <= bit_ops_pkg::PAGE_EXT_RESET;
            result_q <= bit_ops_pkg::DATA_RESET;
            result_write_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            pm_addr_q <= 24'h000000;
            pm_read_q <= 1'b0;
            stack_write_q <= 1'b0;
            stack_read_q <= 1'b0;
            stack_wdata_q <= bit_ops_pkg::DATA_RESET;
            io_read_q <= 1'b0;
            io_write_q <= 1'b0;
            io_wdata_q <= bit_ops_pkg::DATA_RESET;
            sleep_q <= 1'b0;
            wdt_q <= 1'b0;
            break_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            index_q <= index_d;
            inc_q <= inc_d;
            flag_q <= flag_d;
            ptr_q <= ptr_d;
            page_q <= page_d;
            result_q <= result_d;
            result_write_q <= result_write_d;
            busy_q <= busy_d;
            done_q <= done_d;
            pm_addr_q <= pm_addr_d;
            pm_read_q <= pm_read_d;
            stack_write_q <= stack_write_d;
            stack_read_q <= stack_read_d;
            stack_wdata_q <= stack_wdata_d;
            io_read_q <= io_read_d;
            io_write_q <= io_write_d;
            io_wdata_q <= io_wdata_d;
            sleep_q <= sleep_d;
            wdt_q <= wdt_d;
            break_q <= break_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign status_register = flag_q;
    assign pointer = ptr_q;
    assign page_extension_register = page_q;
    assign result = result_q;
    assign result_write = result_write_q;
    assign program_memory_address = pm_addr_q;
    assign program_memory_read = pm_read_q;
    assign stack_write = stack_write_q;
    assign stack_read = stack_read_q;
    assign stack_write_data = stack_wdata_q;
    assign io_read = io_read_q;
    assign io_write = io_write_q;
    assign io_write_data = io_wdata_q;
    assign sleep_request = sleep_q;
    assign watchdog_restart = wdt_q;
    assign debug_break = break_q;
endmodule

// ===== exec_if.sv
// Interface carrying the shift unit's operands and result between the modules of this block.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface exec_if;
    bit_ops_pkg::op_type op;
    logic [7:0] operand;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    logic zero;
    logic negative;
    logic overflow;
    modport unit (input op, input operand, input carry_in,
                  output result, output carry_out, output zero, output negative, output overflow);
    modport user (output op, output operand, output carry_in,
                  input result, input carry_out, input zero, input negative, input overflow);
endinterface

// ===== shift_unit.sv
// Combinational shift and rotate unit with flag generation.
// Assumes the caller latches the results on its own clock.
`timescale 1ns/1ns
module shift_unit (
    exec_if.unit bus
);
    always_comb begin
        bus.result = bus.operand;
        bus.carry_out = bus.carry_in;
        unique case (bus.op)
            bit_ops_pkg::OP_SHL: begin
                bus.result = {bus.operand[6:0], 1'b0};
                bus.carry_out = bus.operand[7];
            end
            bit_ops_pkg::OP_SHR: begin
                bus.result = {1'b0, bus.operand[7:1]};
                bus.carry_out = bus.operand[0];
            end
            bit_ops_pkg::OP_RCL: begin
                bus.result = {bus.operand[6:0], bus.carry_in};
                bus.carry_out = bus.operand[7];
            end
            bit_ops_pkg::OP_RCR: begin
                bus.result = {bus.carry_in, bus.operand[7:1]};
                bus.carry_out = bus.operand[0];
            end
            bit_ops_pkg::OP_SAR: begin
                bus.result = {bus.operand[7], bus.operand[7:1]};
                bus.carry_out = bus.operand[0];
            end
            default: begin
                bus.result = bus.operand;
                bus.carry_out = bus.carry_in;
            end
        endcase
        bus.negative = bus.result[7];
        bus.zero = (bus.result == 8'h00);
        bus.overflow = bus.result[7] ^ bus.carry_out;
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the execution unit: loads, stack, I/O bits, shifts, flags and control ops.
// Assumes the port checker is bound to the unit from its own file.
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic issue = 1'b0;
    bit_ops_pkg::op_type op = bit_ops_pkg::OP_NOP;
    logic [7:0] operand = 8'h00;
    logic [2:0] bit_index = 3'h0;
    logic post_increment = 1'b0;
    logic pointer_load = 1'b0;
    logic [15:0] pointer_value = 16'h0000;
    logic page_extension_load = 1'b0;
    logic [7:0] page_extension_value = 8'h00;
    logic [7:0] program_memory_data = 8'h00;
    logic [7:0] stack_data = 8'h00;
    logic [7:0] io_data = 8'h00;
    logic busy, done, result_write, program_memory_read, stack_write, stack_read, io_read, io_write;
    logic sleep_request, watchdog_restart, debug_break;
    logic [7:0] status_register, page_extension_register, result, stack_write_data, io_write_data;
    logic [15:0] pointer;
    logic [23:0] program_memory_address;
    int err_count = 0;
    int tests_run = 0;
    int seed = 32'h45C1C61F;
    logic [7:0] flag_e = 8'h00;
    logic [23:0] ptr_e;
    logic [7:0] d;
    logic [7:0] v;
    logic [11:0] f;
    logic [2:0] b;
    bit_ops_pkg::op_type o;

    always #50 clk = ~clk;

    bit_ops_transfer_exec dut (.clk, .reset_n, .issue, .op, .operand, .bit_index, .post_increment, .pointer_load,
        .pointer_value, .page_extension_load, .page_extension_value, .program_memory_data, .stack_data, .io_data,
        .busy, .done, .status_register, .pointer, .page_extension_register, .result, .result_write,
        .program_memory_address, .program_memory_read, .stack_write, .stack_read, .stack_write_data, .io_read,
        .io_write, .io_write_data, .sleep_request, .watchdog_restart, .debug_break);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // One issue pulse; returns just after the edge that takes it, so the first answer cycle is visible.
    task automatic start(input bit_ops_pkg::op_type t, input logic [7:0] x, input logic [2:0] i, input logic inc);
        @(posedge clk);
        issue <= 1'b1;
        op <= t;
        operand <= x;
        bit_index <= i;
        post_increment <= inc;
        program_memory_data <= v;
        stack_data <= v;
        io_data <= v;
        @(posedge clk);
        issue <= 1'b0;
        #1;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Returns {V, N, Z, C, result} for a shift or rotate.
    function automatic logic [11:0] shift_model(input bit_ops_pkg::op_type t, input logic [7:0] x, input logic c);
        logic [7:0] r;
        logic co;
        case (t)
            bit_ops_pkg::OP_SHL: {co, r} = {x, 1'b0};
            bit_ops_pkg::OP_SHR: {r, co} = {1'b0, x};
            bit_ops_pkg::OP_RCL: {co, r} = {x, c};
            bit_ops_pkg::OP_RCR: {r, co} = {c, x};
            default: {r, co} = {x[7], x};
        endcase
        return {r[7] ^ co, r[7], r == 8'h00, co, r};
    endfunction

    task automatic test_done();
        $display("Checks run %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(3000 * 100);
        err_count++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("reset", {busy, done, status_register, pointer}, 32'h0);
        chk("reset_page", page_extension_register, 32'h0);
        for (int n = 0; n < 32; n++) begin
            v = 8'($random(seed));
            b = (n < 16) ? n[2:0] : v[3:1];
            o = ((n < 16) ? n[3] : v[0]) ? bit_ops_pkg::OP_FLAG_CLEAR : bit_ops_pkg::OP_FLAG_SET;
            flag_e[b] = (o == bit_ops_pkg::OP_FLAG_SET);
            start(o, v, b, 1'b0);
            chk("flag", {done, status_register}, {1'b1, flag_e});
        end
        @(posedge clk);
        pointer_load <= 1'b1;
        pointer_value <= 16'hFFFF;
        page_extension_load <= 1'b1;
        page_extension_value <= 8'h01;
        @(posedge clk);
        pointer_load <= 1'b0;
        page_extension_load <= 1'b0;
        ptr_e = 24'h01FFFF;
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            o = k[0] ? bit_ops_pkg::OP_PMEM_LOAD : bit_ops_pkg::OP_EXT_PMEM_LOAD;
            start(o, 8'h00, 3'h0, !k[1]);
            chk("pm_read", program_memory_read, 1'b1);
            chk("pm_addr", program_memory_address, k[0] ? {8'h00, ptr_e[15:0]} : ptr_e);
            // A flag op offered mid-load must be dropped, which the flag check below proves.
            @(posedge clk);
            issue <= 1'b1;
            op <= flag_e[0] ? bit_ops_pkg::OP_FLAG_CLEAR : bit_ops_pkg::OP_FLAG_SET;
            bit_index <= bit_ops_pkg::FLAG_C;
            #1;
            chk("pm_early", done, 1'b0);
            @(posedge clk);
            issue <= 1'b0;
            #1;
            if (!k[1]) ptr_e = k[0] ? {ptr_e[23:16], ptr_e[15:0] + 16'h0001} : ptr_e + 24'h000001;
            chk("pm_done", {done, result, status_register}, {1'b1, v, flag_e});
            chk("pm_ptr", {page_extension_register, pointer}, ptr_e);
        end
        for (int n = 0; n < 8; n++) begin
            d = 8'($random(seed));
            v = 8'($random(seed));
            b = 3'(n + 3);
            start(bit_ops_pkg::OP_PUSH, d, b, 1'b0);
            chk("push", {stack_write, stack_write_data, done, busy}, {1'b1, d, 2'b01});
            step();
            chk("push_end", {stack_write, done, busy, status_register}, {3'b010, flag_e});
            start(bit_ops_pkg::OP_POP, d, b, 1'b0);
            chk("pop", {stack_read, done}, 2'b10);
            step();
            chk("pop_end", {done, result_write, result, status_register}, {2'b11, v, flag_e});
            o = n[0] ? bit_ops_pkg::OP_IO_BIT_CLEAR : bit_ops_pkg::OP_IO_BIT_SET;
            start(o, d, b, 1'b0);
            chk("io_read", {io_read, done}, 2'b10);
            step();
            d = n[0] ? v & ~(8'h01 << b) : v | (8'h01 << b);
            chk("io_write", {io_write, done, io_write_data, status_register}, {2'b11, d, flag_e});
        end
        for (int n = 0; n < 40; n++) begin
            o = bit_ops_pkg::op_type'(5'h07 + 5'(n % 5));
            d = (n < 5) ? 8'h80 : (n < 10) ? 8'h01 : 8'($random(seed));
            f = shift_model(o, d, flag_e[0]);
            flag_e[3:0] = f[11:8];
            start(o, d, 3'h0, 1'b0);
            chk("shift", {done, result_write, result}, {2'b11, f[7:0]});
            chk("shift_flags", status_register, flag_e);
        end
        for (int n = 0; n < 8; n++) begin
            d = 8'($random(seed));
            b = n[2:0];
            flag_e[6] = d[b];
            start(bit_ops_pkg::OP_BIT_STORE, d, b, 1'b0);
            chk("bit_store", status_register, flag_e);
            d = ~d;
            start(bit_ops_pkg::OP_BIT_LOAD, d, b, 1'b0);
            d[b] = flag_e[6];
            chk("bit_load", {result_write, result, status_register}, {1'b1, d, flag_e});
        end
        for (int k = 0; k < 4; k++) begin
            o = (k == 0) ? bit_ops_pkg::OP_NOP : bit_ops_pkg::op_type'(5'h0F + 5'(k));
            start(o, 8'hFF, 3'h7, 1'b0);
            f = (k == 0) ? 12'h001 : (k == 1) ? 12'h009 : (k == 2) ? 12'h005 : 12'h002;
            chk("ctrl", {sleep_request, watchdog_restart, debug_break, done, result_write, status_register},
                {f[3:0], 1'b0, flag_e});
            step();
            chk("ctrl_end", {sleep_request, watchdog_restart, debug_break}, 3'h0);
        end
        test_done();
    end
endmodule
